// ---- pkg/aisdr_pkg.sv ----
// Package for the accelerometer identification, status and data register bank.
// Assumes one 125 MHz clock shared by the register port and the sensing logic.
package aisdr_pkg;

	// Register offsets
	localparam logic [7:0] OFS_MAKER_CODE = 8'h00;
	localparam logic [7:0] OFS_FAMILY_CODE = 8'h01;
	localparam logic [7:0] OFS_PART_CODE = 8'h02;
	localparam logic [7:0] OFS_SILICON_REVISION_CODE = 8'h03;
	localparam logic [7:0] OFS_X_ACCEL_COARSE = 8'h08;
	localparam logic [7:0] OFS_Y_ACCEL_COARSE = 8'h09;
	localparam logic [7:0] OFS_Z_ACCEL_COARSE = 8'h0a;
	localparam logic [7:0] OFS_CONDITION_FLAGS = 8'h0b;
	localparam logic [7:0] OFS_QUEUE_COUNT_LOW = 8'h0c;
	localparam logic [7:0] OFS_QUEUE_COUNT_HIGH = 8'h0d;
	localparam logic [7:0] OFS_X_ACCEL_LOW = 8'h0e;
	localparam logic [7:0] OFS_X_ACCEL_HIGH = 8'h0f;
	localparam logic [7:0] OFS_SOFT_RESET = 8'h1f;

	// Software reset code and its settling time
	localparam logic [7:0] SOFT_RESET_CODE = 8'h52;
	localparam int SOFT_RESET_WAIT_NS = 500000;
	localparam int CLOCK_PERIOD_NS = 8;
	localparam int SOFT_RESET_WAIT_CYCLES = (SOFT_RESET_WAIT_NS + CLOCK_PERIOD_NS - 1)
		/ CLOCK_PERIOD_NS;

	// Condition flag bit positions
	localparam int FLG_UPSET = 7;
	localparam int FLG_AWAKE = 6;
	localparam int FLG_INACT = 5;
	localparam int FLG_ACT = 4;
	localparam int FLG_OVERRUN = 3;
	localparam int FLG_WATERMARK = 2;
	localparam int FLG_READY = 1;
	localparam int FLG_DATA_READY = 0;

	// Reset values
	localparam logic [7:0] CONDITION_FLAGS_RESET = 8'h40;
	localparam logic [7:0] DATA_RESET = 8'h00;
	localparam logic [11:0] SAMPLE_RESET = 12'h000;

	// Documented queue depth and sample width
	localparam int QUEUE_DEPTH = 512;
	localparam int SAMPLE_BITS = 12;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} aisdr_req_t;

	typedef struct packed {
		logic valid;
		logic [11:0] x;
		logic [11:0] y;
		logic [11:0] z;
	} aisdr_sample_t;

	typedef struct packed {
		logic act;
		logic inact;
		logic upset;
		logic queue_read;
	} aisdr_event_t;

endpackage : aisdr_pkg

// ---- design/aisdr_regs.sv ----
// Identification, condition flag, queue count and x-axis sample register bank.
// Assumes the register port, the sample source and the detectors all run on i_clock;
// the serial front end that turns host frames into register strobes sits outside.
//
// Functional notes
// - Four read-only identification bytes at offsets 0x00 to 0x03.
// - Coarse 8-bit x, y, z samples readable at 0x08, 0x09, 0x0A.
// - Condition flags reset to 0xC0; only the upset and awake bits are one.
// - Upset flag set at startup and soft reset, cleared by any other write.
// - Upset flag also set when a register setting is disturbed.
// - Awake bit follows the active or inactive state.
// - Awake bit stays one unless linked mode is on.
// - Inactivity flag set when inactivity or free fall is found.
// - Activity flag set when acceleration exceeds the threshold.
// - Overrun flag set when the queue overwrites unread samples.
// - Watermark flag set while the queue holds at least the set count; the code treats a zero mark as a mark of one.
// - Ready flag set while at least one sample waits in the queue.
// - Data-ready set by a new sample, cleared by a queue read.
// - Queue count 0 to 512, low byte at 0x0C.
// - Offset 0x0D holds the two top count bits in its low positions.
// - Full x sample: low byte at 0x0E, upper nibble at 0x0F low.
// - Bits 15 to 12 of the x pair copy bit 11.
// - Code 0x52 to the soft reset offset clears settings; host waits 0.5 ms.
//
// The address-and-strobe port was left to the implementer.
module aisdr_regs #(
	parameter int RESET_WAIT_CYCLES = aisdr_pkg::SOFT_RESET_WAIT_CYCLES,
	parameter int DEPTH = aisdr_pkg::QUEUE_DEPTH,
	parameter logic [7:0] MAKER_CODE = 8'h5a,
	parameter logic [7:0] FAMILY_CODE = 8'h33,
	parameter logic [7:0] PART_CODE = 8'h6c,
	parameter logic [7:0] REVISION_CODE = 8'h02
) (
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire aisdr_pkg::aisdr_req_t i_req,
	input wire aisdr_pkg::aisdr_sample_t i_sample,
	input wire aisdr_pkg::aisdr_event_t i_event,
	input wire logic i_linked_mode,
	input wire logic i_awake_state,
	input wire logic i_queue_overrun,
	input wire logic [9:0] i_queue_count,
	input wire logic [9:0] i_queue_mark,
	output logic [7:0] o_rdata,
	output logic o_soft_reset,
	output logic o_reset_busy
);
	import aisdr_pkg::*;

	// Identification defaults above are arbitrary neutral values.

	if (DEPTH < 1 || DEPTH > 1023) begin : g_bad_depth
		$error("queue depth does not fit the 10-bit count");
	end
	if (RESET_WAIT_CYCLES < 1) begin : g_bad_wait
		$error("soft reset wait must be at least one cycle");
	end

	logic [11:0] x_q;
	logic [11:0] y_q;
	logic [11:0] z_q;
	logic upset_q;
	logic act_q;
	logic inact_q;
	logic overrun_q;
	logic data_ready_q;
	logic [9:0] count_q;
	logic [9:0] mark_q;
	logic awake_q;
	logic [31:0] wait_cnt_q;
	logic [7:0] rdata_q;
	logic soft_reset_q;
	logic reset_busy_q;
	logic [7:0] flags;
	logic soft_hit;
	logic status_read;
	logic take_sample;
	logic [31:0] busy_len_q;

	function automatic logic [7:0] coarse(input logic [11:0] s);
		coarse = s[11:4];
	endfunction : coarse

	assign soft_hit = i_req.wr && (i_req.addr == OFS_SOFT_RESET)
		&& (i_req.wdata == SOFT_RESET_CODE);
	assign status_read = i_req.rd && (i_req.addr == OFS_CONDITION_FLAGS);
	// Samples are held off while the soft reset settles, so the cleared state is seen
	assign take_sample = i_sample.valid && !reset_busy_q && !soft_hit;

	// Sample capture: all three axes in one edge, so every view agrees
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			x_q <= SAMPLE_RESET;
			y_q <= SAMPLE_RESET;
			z_q <= SAMPLE_RESET;
		end else if (soft_hit) begin
			x_q <= SAMPLE_RESET;
			y_q <= SAMPLE_RESET;
			z_q <= SAMPLE_RESET;
		end else if (take_sample) begin
			x_q <= i_sample.x;
			y_q <= i_sample.y;
			z_q <= i_sample.z;
		end
	end

	// Upset flag: set wins over the clear by a write
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			upset_q <= 1'b1;
		end else if (soft_hit || i_event.upset) begin
			upset_q <= 1'b1;
		end else if (i_req.wr) begin
			upset_q <= 1'b0;
		end
	end

	// Activity and inactivity flags are sticky until the flags are read
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			act_q <= 1'b0;
			inact_q <= 1'b0;
		end else if (soft_hit) begin
			act_q <= 1'b0;
			inact_q <= 1'b0;
		end else begin
			act_q <= i_event.act || (act_q && !status_read);
			inact_q <= i_event.inact || (inact_q && !status_read);
		end
	end

	// Data-ready: a new sample in the same cycle as a queue read keeps it set
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			data_ready_q <= 1'b0;
		end else if (soft_hit) begin
			data_ready_q <= 1'b0;
		end else if (take_sample) begin
			data_ready_q <= 1'b1;
		end else if (i_event.queue_read) begin
			data_ready_q <= 1'b0;
		end
	end

	// Queue state is a registered copy of the queue logic, count held at DEPTH; awake level copies the awake state in linked mode only
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			count_q <= '0;
			mark_q <= '0;
			overrun_q <= 1'b0;
			awake_q <= CONDITION_FLAGS_RESET[FLG_AWAKE];
		end else if (soft_hit) begin
			count_q <= '0;
			mark_q <= '0;
			overrun_q <= 1'b0;
			awake_q <= 1'b1;
		end else begin
			count_q <= (i_queue_count > 10'(DEPTH)) ? 10'(DEPTH) : i_queue_count;
			mark_q <= i_queue_mark;
			overrun_q <= i_queue_overrun;
			awake_q <= i_linked_mode ? i_awake_state : 1'b1;
		end
	end

	always_comb begin
		flags = 8'h00;
		flags[FLG_UPSET] = upset_q;
		flags[FLG_AWAKE] = awake_q;
		flags[FLG_INACT] = inact_q;
		flags[FLG_ACT] = act_q;
		flags[FLG_OVERRUN] = overrun_q;
		// A zero mark would always fire; it is treated as a mark of one
		flags[FLG_WATERMARK] = (count_q != '0) && (count_q >= mark_q);
		flags[FLG_READY] = (count_q != '0);
		flags[FLG_DATA_READY] = data_ready_q;
	end

	// Soft reset pulse and settling window
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			soft_reset_q <= 1'b0;
			reset_busy_q <= 1'b0;
			wait_cnt_q <= '0;
		end else if (soft_hit) begin
			soft_reset_q <= 1'b1;
			reset_busy_q <= 1'b1;
			wait_cnt_q <= 32'(RESET_WAIT_CYCLES - 1);
		end else begin
			soft_reset_q <= 1'b0;
			if (wait_cnt_q != '0) begin
				wait_cnt_q <= wait_cnt_q - 32'd1;
			end else begin
				reset_busy_q <= 1'b0;
			end
		end
	end

	// Read data stands only in the cycle after the read strobe
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rdata_q <= DATA_RESET;
		end else if (!i_req.rd) begin
			rdata_q <= DATA_RESET;
		end else begin
			unique case (i_req.addr)
				OFS_MAKER_CODE: rdata_q <= MAKER_CODE;
				OFS_FAMILY_CODE: rdata_q <= FAMILY_CODE;
				OFS_PART_CODE: rdata_q <= PART_CODE;
				OFS_SILICON_REVISION_CODE: rdata_q <= REVISION_CODE;
				OFS_X_ACCEL_COARSE: rdata_q <= coarse(x_q);
				OFS_Y_ACCEL_COARSE: rdata_q <= coarse(y_q);
				OFS_Z_ACCEL_COARSE: rdata_q <= coarse(z_q);
				OFS_CONDITION_FLAGS: rdata_q <= flags;
				OFS_QUEUE_COUNT_LOW: rdata_q <= count_q[7:0];
				OFS_QUEUE_COUNT_HIGH: rdata_q <= {6'h00, count_q[9:8]};
				OFS_X_ACCEL_LOW: rdata_q <= x_q[7:0];
				OFS_X_ACCEL_HIGH: rdata_q <= {{4{x_q[11]}}, x_q[11:8]};
				default: rdata_q <= DATA_RESET;
			endcase
		end
	end

	assign o_rdata = rdata_q;
	assign o_soft_reset = soft_reset_q;
	assign o_reset_busy = reset_busy_q;

	// Counts the settling window apart from the down-counter, so its length can be checked
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			busy_len_q <= '0;
		end else if (soft_reset_q) begin
			busy_len_q <= 32'd1;
		end else if (reset_busy_q) begin
			busy_len_q <= busy_len_q + 32'd1;
		end
	end

	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (!i_rst_n);

	sequence s_soft_write;
		i_req.wr && i_req.addr == OFS_SOFT_RESET && i_req.wdata == SOFT_RESET_CODE;
	endsequence

	sequence s_settle;
		(o_reset_busy && !o_soft_reset) [*4];
	endsequence

	sequence s_linked_read;
		i_linked_mode && !soft_hit ##1 status_read;
	endsequence

	property p_upset_clear;
		i_req.wr && !soft_hit && !i_event.upset |=> !upset_q;
	endproperty
	a_upset_clear: assert property (p_upset_clear) else $error("upset flag not cleared");

	property p_soft_reset;
		s_soft_write |=> o_soft_reset && upset_q && !data_ready_q ##1 s_settle;
	endproperty
	a_soft_reset: assert property (p_soft_reset) else $error("soft reset sequence wrong");

	property p_upset_event;
		i_event.upset |=> upset_q;
	endproperty
	a_upset_event: assert property (p_upset_event) else $error("upset not flagged");

	property p_data_ready;
		take_sample |=> data_ready_q && x_q == $past(i_sample.x);
	endproperty
	a_data_ready: assert property (p_data_ready) else $error("sample not captured");

	property p_data_ready_clear;
		i_event.queue_read && !take_sample |=> !data_ready_q;
	endproperty
	a_data_ready_clear: assert property (p_data_ready_clear) else $error("ready kept");

	property p_awake_unlinked;
		!i_linked_mode ##1 !i_linked_mode && status_read |=> o_rdata[FLG_AWAKE];
	endproperty
	a_awake_unlinked: assert property (p_awake_unlinked) else $error("awake bit low");

	property p_x_high_sign;
		i_req.rd && i_req.addr == OFS_X_ACCEL_HIGH |=> o_rdata[7:4] == {4{o_rdata[3]}};
	endproperty
	a_x_high_sign: assert property (p_x_high_sign) else $error("sign fill wrong");

	property p_x_views_agree;
		i_req.rd && i_req.addr == OFS_X_ACCEL_COARSE && !take_sample
			|=> o_rdata == x_q[11:4];
	endproperty
	a_x_views_agree: assert property (p_x_views_agree) else $error("coarse x mismatch");

	property p_count_high;
		i_req.rd && i_req.addr == OFS_QUEUE_COUNT_HIGH |=> o_rdata[7:2] == 6'h00;
	endproperty
	a_count_high: assert property (p_count_high) else $error("count high bits set");

	property p_read_once;
		!i_req.rd |=> o_rdata == 8'h00;
	endproperty
	a_read_once: assert property (p_read_once) else $error("read data held");

	property p_ready_flag;
		status_read |=> o_rdata[FLG_READY] == ($past(count_q) != 10'h000);
	endproperty
	a_ready_flag: assert property (p_ready_flag) else $error("ready flag wrong");

	property p_busy_length;
		$fell(reset_busy_q) |-> busy_len_q == 32'(RESET_WAIT_CYCLES);
	endproperty
	a_busy_length: assert property (p_busy_length) else $error("settle length wrong");

	property p_sample_hold;
		reset_busy_q && i_sample.valid && !soft_hit |=> $stable(x_q) && $stable(y_q);
	endproperty
	a_sample_hold: assert property (p_sample_hold) else $error("sample while settling");

	property p_soft_clear;
		s_soft_write |=> x_q == SAMPLE_RESET && count_q == 10'h000 && !act_q && !inact_q;
	endproperty
	a_soft_clear: assert property (p_soft_clear) else $error("soft reset kept state");

	property p_act_set;
		i_event.act && !soft_hit |=> act_q;
	endproperty
	a_act_set: assert property (p_act_set) else $error("activity not flagged");

	property p_act_hold;
		act_q && !status_read && !soft_hit |=> act_q;
	endproperty
	a_act_hold: assert property (p_act_hold) else $error("activity flag lost");

	property p_act_clear;
		status_read && !i_event.act |=> !act_q;
	endproperty
	a_act_clear: assert property (p_act_clear) else $error("activity flag kept");

	property p_inact_set;
		i_event.inact && !soft_hit |=> inact_q;
	endproperty
	a_inact_set: assert property (p_inact_set) else $error("inactivity not flagged");

	property p_inact_hold;
		inact_q && !status_read && !soft_hit |=> inact_q;
	endproperty
	a_inact_hold: assert property (p_inact_hold) else $error("inactivity flag lost");

	property p_overrun;
		!soft_hit ##1 status_read |=> o_rdata[FLG_OVERRUN] == $past(i_queue_overrun, 2);
	endproperty
	a_overrun: assert property (p_overrun) else $error("overrun flag wrong");

	property p_watermark;
		status_read && count_q != 10'h000
			|=> o_rdata[FLG_WATERMARK] == ($past(count_q) >= $past(mark_q));
	endproperty
	a_watermark: assert property (p_watermark) else $error("watermark flag wrong");

	property p_count_range;
		count_q <= 10'(DEPTH);
	endproperty
	a_count_range: assert property (p_count_range) else $error("count above depth");

	property p_count_low;
		i_req.rd && i_req.addr == OFS_QUEUE_COUNT_LOW
			|=> {2'b00, o_rdata} == ($past(count_q) & 10'h0ff);
	endproperty
	a_count_low: assert property (p_count_low) else $error("count low byte wrong");

	property p_x_low;
		i_req.rd && i_req.addr == OFS_X_ACCEL_LOW
			|=> {4'h0, o_rdata} == ($past(x_q) & 12'h0ff);
	endproperty
	a_x_low: assert property (p_x_low) else $error("x low byte wrong");

	property p_awake_linked;
		s_linked_read |=> o_rdata[FLG_AWAKE] == $past(i_awake_state, 2);
	endproperty
	a_awake_linked: assert property (p_awake_linked) else $error("awake bit wrong");

	property p_id_maker;
		i_req.rd && i_req.addr == OFS_MAKER_CODE |=> o_rdata == MAKER_CODE;
	endproperty
	a_id_maker: assert property (p_id_maker) else $error("maker code wrong");

	property p_unmapped;
		i_req.rd && i_req.addr[7:2] == 6'h01 |=> o_rdata == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

endmodule : aisdr_regs

// ---- verification/aisdr_host.sv ----
// Host model that reaches the register bank over its plain register port.
// Assumes the bank answers a read in the cycle after the strobe and never stalls.
module aisdr_host #(
	parameter int WAIT = 8
) (
	input wire logic i_clock,
	input wire logic [7:0] i_rdata,
	output aisdr_pkg::aisdr_req_t o_req
);
	timeunit 1ns;
	timeprecision 1ps;
	import aisdr_pkg::*;
	initial o_req = '0;
	// Writes only target read-only places or the soft reset offset
	task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clock);
		o_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge i_clock);
		o_req.wr <= 1'b0;
	endtask : write_reg
	task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge i_clock);
		o_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge i_clock);
		o_req.rd <= 1'b0;
		// Read data stand for one cycle only; take them at the edge that closes it
		@(posedge i_clock);
		d = i_rdata;
	endtask : read_reg
	task automatic reset_device();
		write_reg(OFS_SOFT_RESET, SOFT_RESET_CODE);
		repeat (WAIT) @(posedge i_clock);
	endtask : reset_device
endmodule : aisdr_host

// ---- verification/tb_accel_id_status_data_regs.sv ----
// Self-checking bench for the identification, status and data register bank.
// Assumes one clock for port, samples and detector inputs; host model drives the port.
module tb_accel_id_status_data_regs;
	timeunit 1ns;
	timeprecision 1ps;
	import aisdr_pkg::*;
	localparam int WAIT = 8;
	// Arbitrary identity values
	localparam logic [7:0] IDS [4] = '{8'h3c, 8'h47, 8'h9e, 8'h05};
	logic i_clock = 1'b0;
	logic i_rst_n = 1'b0;
	aisdr_req_t req;
	aisdr_sample_t smp = '0;
	aisdr_event_t ev = '0;
	logic lnk = 1'b0, awk = 1'b1, ovr = 1'b0;
	logic [9:0] cnt = '0, mark = '0;
	logic [7:0] rdata;
	logic srst, busy;
	int bad_count = 0, total_checks = 0, pulses = 0;
	logic [31:0] lf = 32'hb892;
	logic [11:0] x, y, z;
	// Model of the samples handed over; the newest is what every x view must show
	logic [11:0] xs [$];
	always #4 i_clock = ~i_clock;
	always @(posedge i_clock) if (srst === 1'b1) pulses++;
	aisdr_regs #(.RESET_WAIT_CYCLES(WAIT), .MAKER_CODE(IDS[0]), .FAMILY_CODE(IDS[1]),
		.PART_CODE(IDS[2]), .REVISION_CODE(IDS[3])) DUT (.i_clock(i_clock), .i_rst_n(i_rst_n),
		.i_req(req), .i_sample(smp), .i_event(ev), .i_linked_mode(lnk), .i_awake_state(awk),
		.i_queue_overrun(ovr), .i_queue_count(cnt), .i_queue_mark(mark), .o_rdata(rdata),
		.o_soft_reset(srst), .o_reset_busy(busy));
	aisdr_host #(.WAIT(WAIT)) host (.i_clock(i_clock), .i_rdata(rdata), .o_req(req));
	function automatic logic [31:0] nxt(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : nxt
	task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
		total_checks++;
		if (s !== e) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic rc(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		host.read_reg(a, d);
		chk($sformatf("reg %h", a), d, e);
	endtask : rc
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : end_of_test
	initial begin
		repeat (20000) @(posedge i_clock);
		bad_count++;
		end_of_test();
	end
	initial begin
		repeat (20) @(posedge i_clock);
		i_rst_n <= 1'b1;
		for (int i = 0; i < 4; i++) rc(i[7:0], IDS[i]);
		rc(8'h04, 8'h00);
		rc(OFS_CONDITION_FLAGS, 8'hc0);
		for (int i = 8; i < 16; i++) if (i != 11) rc(i[7:0], 8'h00);
		lf = nxt(lf);
		host.write_reg(OFS_X_ACCEL_COARSE, lf[7:0]);
		host.write_reg(OFS_SOFT_RESET, 8'h25);
		rc(OFS_X_ACCEL_COARSE, 8'h00);
		rc(OFS_CONDITION_FLAGS, 8'h40);
		for (int k = 0; k < 2; k++) begin
			lf = nxt(lf);
			x = {k[0], lf[10:0]};
			y = lf[22:11];
			z = lf[31:20];
			xs.push_back(x);
			@(posedge i_clock);
			smp <= '{valid: 1'b1, x: x, y: y, z: z};
			@(posedge i_clock);
			smp.valid <= 1'b0;
			rc(OFS_X_ACCEL_COARSE, xs[$][11:4]);
			rc(OFS_Y_ACCEL_COARSE, y[11:4]);
			rc(OFS_Z_ACCEL_COARSE, z[11:4]);
			rc(OFS_X_ACCEL_LOW, xs[$][7:0]);
			rc(OFS_X_ACCEL_HIGH, {{4{x[11]}}, x[11:8]});
			rc(OFS_CONDITION_FLAGS, 8'h41);
		end
		@(posedge i_clock);
		ev.queue_read <= 1'b1;
		@(posedge i_clock);
		ev.queue_read <= 1'b0;
		rc(OFS_CONDITION_FLAGS, 8'h40);
		@(posedge i_clock);
		ev <= '{act: 1'b1, inact: 1'b1, upset: 1'b1, queue_read: 1'b0};
		{lnk, awk, ovr, cnt, mark} <= {1'b1, 1'b0, 1'b1, 10'd512, 10'd100};
		@(posedge i_clock);
		ev <= '0;
		repeat (2) @(posedge i_clock);
		rc(OFS_CONDITION_FLAGS, 8'hbe);
		rc(OFS_CONDITION_FLAGS, 8'h8e);
		rc(OFS_QUEUE_COUNT_LOW, 8'h00);
		rc(OFS_QUEUE_COUNT_HIGH, 8'h02);
		awk <= 1'b1;
		rc(OFS_CONDITION_FLAGS, 8'hce);
		{lnk, awk, ovr, cnt} <= {1'b0, 1'b0, 1'b0, 10'd0};
		rc(OFS_CONDITION_FLAGS, 8'hc0);
		// A sample offered inside the settling window must be refused
		fork
			host.reset_device();
			begin
				repeat (3) @(posedge i_clock);
				smp <= '{valid: 1'b1, x: 12'h7ff, y: 12'h7ff, z: 12'h7ff};
				@(posedge i_clock);
				smp.valid <= 1'b0;
			end
		join
		chk("pulses", pulses[7:0], 8'h01);
		chk("busy", {7'h00, busy}, 8'h01);
		@(posedge i_clock);
		chk("busy", {7'h00, busy}, 8'h00);
		rc(OFS_X_ACCEL_COARSE, 8'h00);
		rc(OFS_X_ACCEL_HIGH, 8'h00);
		rc(OFS_CONDITION_FLAGS, 8'hc0);
		end_of_test();
	end
endmodule : tb_accel_id_status_data_regs
